// ---- pom_top.sv ----
/*
  Parallel output stage: formats decoded words for the output bus, routes
  four status pins under host selects, and carries words and status to
  the word clock domain through a dual clock FIFO.
  Assumes upstream decode logic on sys_clk and downstream logic sampling
  the bus on the word clock, which is link_clk driven out on pclk_o.
*/
//
// Summary of operation
// - The two format pins pick data-through, multiplexed video or transport output.
// - Format pins are inputs in manual mode and driven status outputs in auto mode.
// - Reset floats bus and word clock while status pins hold their last state.
// - Video mode puts aligned luma and chroma words on all ten bus bits.
// - Transport mode puts the decoded byte on bits 7 to 0, msb on bit 7.
// - Transport mode puts code word fault on bit 9 and sync flag on bit 8.
// - Data-through mode passes the raw ten bit word unchanged.
// - Auto mode with nothing identified forces the data bus low.
// - Four status pins each route one of eight internal signals.
// - Each pin has a three bit select with the fixed eight way encoding.
// - A select naming a signal irrelevant to the mode floats that pin.
// - Buffer full and empty selects float the pin in video mode.
// - Video mode with extraction buffer defaults selects to 0, 1, 2, 3.
// - Transport defaults 6, 7, 0, 0 and data-through defaults all 0.
`default_nettype none
`include "pom_defs.svh"

module pom_top (
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  // Upstream words
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [`POM_WORD_W-1:0] raw_word,
  input wire logic [`POM_WORD_W-1:0] aligned_word,
  input wire logic [7:0] asi_byte,
  input wire logic code_word_fault,
  input wire logic sync_char_flag,
  // Upstream detection and buffer state
  input wire logic video_detected,
  input wire logic transport_detected,
  input wire logic buf_extract_mode,
  // Internal status sources
  input wire logic hblank,
  input wire logic vblank,
  input wire logic field_id,
  input wire logic buffer_load_pulse,
  input wire logic aux_packet_flag,
  input wire logic error_packet_flag,
  input wire logic buffer_full,
  input wire logic buffer_empty,
  // Format pins and auto mode pin
  input wire logic auto_mode,
  input wire logic video_decode_select_i,
  output logic video_decode_select_o,
  output logic video_decode_select_oe_b,
  input wire logic transport_mode_select_i,
  output logic transport_mode_select_o,
  output logic transport_mode_select_oe_b,
  // Select register port
  input wire logic sel_wr_en,
  input wire logic [1:0] sel_addr,
  input wire logic [2:0] sel_wdata,
  output logic [2:0] sel_rdata,
  output logic [1:0] format_status,
  // Parallel output on the word clock
  input wire logic out_hold,
  output logic pclk_o,
  output logic pclk_oe_b,
  output logic [`POM_WORD_W-1:0] dout_o,
  output logic dout_oe_b,
  output logic [`POM_NSTAT-1:0] stat_o,
  output logic [`POM_NSTAT-1:0] stat_oe_b,
  output logic word_strobe
);

  localparam pom_pkg::pom_core_t CORE_RST = '{
    auto_q: 2'h0, vid_q: 2'h0, trn_q: 2'h0,
    sel: {`POM_NSTAT{`POM_SEL_RST}},
    last_mode: pom_pkg::POM_MODE_THRU, first: 1'b1,
    rdata: 3'h0, fmt: 2'h0, pin_o: 2'h0, pin_oe_b: 2'h3};

  pom_pkg::pom_core_t c_r, c_nxt;
  pom_pkg::pom_link_t l_r, l_nxt;
  pom_pkg::pom_mode_t mode;
  logic is_auto;
  logic vid_sel;
  logic trn_sel;
  logic force_zero;
  logic load_defaults;
  logic [7:0] stat_src;
  logic [`POM_WORD_W-1:0] word;
  logic [`POM_NSTAT-1:0] stat_val;
  logic [`POM_NSTAT-1:0] stat_en;
  logic [`POM_ENTRY_W-1:0] entry;
  logic [`POM_ENTRY_W-1:0] rd_entry;
  logic rd_valid;
  logic rd_ready;
  logic lrst;
  logic pop;
  logic push;

  // Whether a select is meaningful in the given mode
  function automatic logic sel_relevant(pom_pkg::pom_mode_t m,
                                        logic [2:0] s);
    logic r;
    r = 1'b0;
    case (m)
      pom_pkg::POM_MODE_VIDEO:
        r = (s != `POM_SEL_FULL) && (s != `POM_SEL_EMPTY);
      pom_pkg::POM_MODE_ASI:
        r = (s == `POM_SEL_FULL) || (s == `POM_SEL_EMPTY) ||
            (s == `POM_SEL_LOAD);
      default:
        r = 1'b0;
    endcase
    return r;
  endfunction

  // Effective format from pins or detection
  always_comb
  begin
    is_auto = c_r.auto_q[1];
    vid_sel = is_auto ? video_detected : c_r.vid_q[1];
    trn_sel = is_auto ? transport_detected : c_r.trn_q[1];
    if (trn_sel)
      mode = pom_pkg::POM_MODE_ASI;
    else if (vid_sel)
      mode = pom_pkg::POM_MODE_VIDEO;
    else
      mode = pom_pkg::POM_MODE_THRU;
    force_zero = is_auto && !video_detected && !transport_detected;
    load_defaults = c_r.first || (mode != c_r.last_mode);
  end

  // Internal status sources in select code order
  assign stat_src = {buffer_empty, buffer_full, error_packet_flag,
                     aux_packet_flag, buffer_load_pulse, field_id,
                     vblank, hblank};

  // Output word and status per mode
  always_comb
  begin
    word = '0;
    case (mode)
      pom_pkg::POM_MODE_VIDEO:
        word = aligned_word;
      pom_pkg::POM_MODE_ASI:
        word = {code_word_fault, sync_char_flag, asi_byte};
      default:
        word = raw_word;
    endcase
    if (force_zero)
      word = '0;
    for (int i = 0; i < `POM_NSTAT; i++)
    begin
      stat_val[i] = stat_src[c_r.sel[i]];
      stat_en[i] = sel_relevant(mode, c_r.sel[i]);
    end
  end

  assign entry = {stat_en, stat_val, word};

  // Core next state: pin sync, selects, read back
  always_comb
  begin
    c_nxt = c_r;
    c_nxt.auto_q = {c_r.auto_q[0], auto_mode};
    c_nxt.vid_q = {c_r.vid_q[0], video_decode_select_i};
    c_nxt.trn_q = {c_r.trn_q[0], transport_mode_select_i};
    c_nxt.first = 1'b0;
    c_nxt.last_mode = mode;
    if (load_defaults)
    begin
      c_nxt.sel = {`POM_NSTAT{`POM_SEL_RST}};
      if (mode == pom_pkg::POM_MODE_VIDEO && buf_extract_mode)
        c_nxt.sel = {`POM_SEL_LOAD, `POM_SEL_FIELD,
                     `POM_SEL_VBLANK, `POM_SEL_HBLANK};
      else if (mode == pom_pkg::POM_MODE_ASI)
        c_nxt.sel = {`POM_SEL_RST, `POM_SEL_RST,
                     `POM_SEL_EMPTY, `POM_SEL_FULL};
    end
    else if (sel_wr_en)
      c_nxt.sel[sel_addr] = sel_wdata;
    c_nxt.rdata = c_r.sel[sel_addr];
    c_nxt.fmt = {trn_sel, vid_sel};
    c_nxt.pin_o = {transport_detected, video_detected};
    c_nxt.pin_oe_b = is_auto ? 2'h0 : 2'h3;
    if (!rst_b)
      c_nxt = CORE_RST;
  end

  // Core registers
  always_ff @(posedge sys_clk)
    c_r <= c_nxt;

  assign video_decode_select_o = c_r.pin_o[0];
  assign transport_mode_select_o = c_r.pin_o[1];
  assign video_decode_select_oe_b = c_r.pin_oe_b[0];
  assign transport_mode_select_oe_b = c_r.pin_oe_b[1];
  assign sel_rdata = c_r.rdata;
  assign format_status = c_r.fmt;
  assign push = in_valid && in_ready;

  // Word buffer crossing into the word clock domain
  pom_fifo #(
    .WIDTH(`POM_ENTRY_W),
    .DEPTH(`POM_FIFO_DEPTH)
  ) u_fifo (
    .wr_clk(sys_clk),
    .wr_rst_b(rst_b),
    .wr_valid(in_valid),
    .wr_ready(in_ready),
    .wr_data(entry),
    .rd_clk(link_clk),
    .rd_rst_b(l_r.rst_q[1]),
    .rd_valid(rd_valid),
    .rd_ready(rd_ready),
    .rd_data(rd_entry)
  );

  assign lrst = !l_r.rst_q[1];
  assign rd_ready = !lrst && !out_hold;
  assign pop = rd_valid && rd_ready;

  // Link next state: outputs move together on the word clock
  always_comb
  begin
    l_nxt = l_r;
    l_nxt.rst_q = {l_r.rst_q[0], rst_b};
    l_nxt.strobe = 1'b0;
    if (lrst)
    begin
      l_nxt.pclk_oe_b = 1'b1;
      l_nxt.dout_oe_b = 1'b1;
    end
    else
    begin
      l_nxt.pclk_oe_b = 1'b0;
      l_nxt.dout_oe_b = 1'b0;
      if (pop)
      begin
        l_nxt.dout = rd_entry[`POM_WORD_W-1:0];
        l_nxt.stat = rd_entry[`POM_EN_LSB-1:`POM_STAT_LSB];
        l_nxt.stat_oe_b = ~rd_entry[`POM_ENTRY_W-1:`POM_EN_LSB];
        l_nxt.strobe = 1'b1;
      end
    end
  end

  // Link registers
  always_ff @(posedge link_clk)
    l_r <= l_nxt;

  assign pclk_o = link_clk;
  assign pclk_oe_b = l_r.pclk_oe_b;
  assign dout_o = l_r.dout;
  assign dout_oe_b = l_r.dout_oe_b;
  assign stat_o = l_r.stat;
  assign stat_oe_b = l_r.stat_oe_b;
  assign word_strobe = l_r.strobe;

  // Checks on the system clock side
  chk_thru_raw: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    push && mode == pom_pkg::POM_MODE_THRU && !force_zero
    |-> entry[`POM_WORD_W-1:0] == raw_word)
    else $error("data-through word altered");

  chk_video_word: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    push && mode == pom_pkg::POM_MODE_VIDEO && !force_zero
    |-> entry[`POM_WORD_W-1:0] == aligned_word)
    else $error("video word not aligned word");

  chk_asi_byte_flags: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    push && mode == pom_pkg::POM_MODE_ASI && !force_zero
    |-> entry[`POM_WORD_W-1:0] ==
        {code_word_fault, sync_char_flag, asi_byte})
    else $error("transport byte or flags misplaced");

  chk_force_low: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    c_r.auto_q[1] && !video_detected && !transport_detected
    |-> entry[`POM_WORD_W-1:0] == '0)
    else $error("bus not forced low without detection");

  chk_full_sel_float: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    mode == pom_pkg::POM_MODE_VIDEO && c_r.sel[0][2:1] == 2'h3
    |-> !entry[`POM_EN_LSB])
    else $error("buffer flag routed in video mode");

  chk_thru_float: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    mode == pom_pkg::POM_MODE_THRU
    |-> entry[`POM_ENTRY_W-1:`POM_EN_LSB] == '0)
    else $error("status pin enabled in data-through");

  chk_asi_defaults: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    load_defaults && mode == pom_pkg::POM_MODE_ASI
    |=> c_r.sel[0] == `POM_SEL_FULL && c_r.sel[1] == `POM_SEL_EMPTY
        && c_r.sel[2] == `POM_SEL_RST && c_r.sel[3] == `POM_SEL_RST)
    else $error("transport default selects wrong");

  chk_video_defaults: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    load_defaults && mode == pom_pkg::POM_MODE_VIDEO && buf_extract_mode
    |=> c_r.sel[3] == `POM_SEL_LOAD && c_r.sel[2] == `POM_SEL_FIELD
        && c_r.sel[1] == `POM_SEL_VBLANK && c_r.sel[0] == `POM_SEL_HBLANK)
    else $error("video default selects wrong");

  chk_auto_drives: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(c_r.auto_q[1]) |=> c_r.pin_oe_b == 2'h0 ##0
    c_r.pin_o == $past({transport_detected, video_detected}))
    else $error("format pins not driven in auto mode");

  // Checks on the word clock side
  chk_reset_float: assert property (
    @(posedge link_clk)
    lrst ##1 lrst |-> dout_oe_b && pclk_oe_b && $stable(stat_o)
    && $stable(stat_oe_b))
    else $error("outputs not floated or status not held in reset");

  chk_word_update: assert property (
    @(posedge link_clk) disable iff (lrst)
    pop |=> word_strobe && dout_o == $past(rd_entry[`POM_WORD_W-1:0])
    && stat_o == $past(rd_entry[`POM_EN_LSB-1:`POM_STAT_LSB]))
    else $error("bus and status not updated together");

  // Main scenarios
  cov_video_push: cover property (
    @(posedge sys_clk) disable iff (!rst_b)
    push && mode == pom_pkg::POM_MODE_VIDEO);
  cov_asi_push: cover property (
    @(posedge sys_clk) disable iff (!rst_b)
    push && mode == pom_pkg::POM_MODE_ASI);
  cov_fifo_full: cover property (
    @(posedge sys_clk) disable iff (!rst_b) in_valid && !in_ready);
  cov_sel_write: cover property (
    @(posedge sys_clk) disable iff (!rst_b) sel_wr_en && !load_defaults);

endmodule

`default_nettype wire

// ---- pom_defs.svh ----
/*
  Constants of the parallel output and status pin mux: entry layout,
  status select codes, default selects and buffer sizing.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef POM_DEFS_SVH
`define POM_DEFS_SVH

// Word and entry layout
`define POM_WORD_W 10
`define POM_NSTAT 4
`define POM_STAT_LSB 10
`define POM_EN_LSB 14
`define POM_ENTRY_W 18

// Buffer sizing
`define POM_FIFO_DEPTH 16

// Status select codes
`define POM_SEL_HBLANK 3'h0
`define POM_SEL_VBLANK 3'h1
`define POM_SEL_FIELD 3'h2
`define POM_SEL_LOAD 3'h3
`define POM_SEL_AUX 3'h4
`define POM_SEL_ERRPKT 3'h5
`define POM_SEL_FULL 3'h6
`define POM_SEL_EMPTY 3'h7

// Select reset value
`define POM_SEL_RST 3'h0

`endif

// ---- pom_pkg.sv ----
/*
  Types of the parallel output and status pin mux.
  Assumes pom_defs.svh is on the include path.
*/
`default_nettype none
`include "pom_defs.svh"

package pom_pkg;

  // Output format
  typedef enum logic [1:0] {
    POM_MODE_THRU,
    POM_MODE_VIDEO,
    POM_MODE_ASI
  } pom_mode_t;

  // System clock side state
  typedef struct packed {
    logic [1:0] auto_q;
    logic [1:0] vid_q;
    logic [1:0] trn_q;
    logic [`POM_NSTAT-1:0][2:0] sel;
    pom_mode_t last_mode;
    logic first;
    logic [2:0] rdata;
    logic [1:0] fmt;
    logic [1:0] pin_o;
    logic [1:0] pin_oe_b;
  } pom_core_t;

  // Link clock side state
  typedef struct packed {
    logic [1:0] rst_q;
    logic pclk_oe_b;
    logic [`POM_WORD_W-1:0] dout;
    logic dout_oe_b;
    logic [`POM_NSTAT-1:0] stat;
    logic [`POM_NSTAT-1:0] stat_oe_b;
    logic strobe;
  } pom_link_t;

endpackage

`default_nettype wire

// ---- pom_fifo.sv ----
/*
  Dual clock FIFO with gray coded pointers, valid and ready on both sides.
  Assumes each side has its own synchronous active low reset.
*/
`default_nettype none
`include "pom_defs.svh"

module pom_fifo #(
  parameter int WIDTH = `POM_ENTRY_W,
  parameter int DEPTH = `POM_FIFO_DEPTH
) (
  // Write side
  input wire logic wr_clk,
  input wire logic wr_rst_b,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic rd_clk,
  input wire logic rd_rst_b,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wbin;
    logic [AW:0] rq1;
    logic [AW:0] rq2;
  } pom_fw_t;

  typedef struct packed {
    logic [AW:0] rbin;
    logic [AW:0] wq1;
    logic [AW:0] wq2;
  } pom_fr_t;

  pom_fw_t w_r, w_nxt;
  pom_fr_t r_r, r_nxt;
  logic [AW:0] wgray;
  logic [AW:0] rgray;

  // Gray images of the binary pointers
  assign wgray = w_r.wbin ^ (w_r.wbin >> 1);
  assign rgray = r_r.rbin ^ (r_r.rbin >> 1);

  // Full and empty from the synchronised far pointer
  assign wr_ready = wr_rst_b &&
    (wgray != {~w_r.rq2[AW:AW-1], w_r.rq2[AW-2:0]});
  assign rd_valid = rd_rst_b && (rgray != r_r.wq2);
  assign rd_data = w_r.mem[r_r.rbin[AW-1:0]];

  // Write side next state
  always_comb
  begin
    w_nxt = w_r;
    w_nxt.rq1 = rgray;
    w_nxt.rq2 = w_r.rq1;
    if (wr_valid && wr_ready)
    begin
      w_nxt.mem[w_r.wbin[AW-1:0]] = wr_data;
      w_nxt.wbin = w_r.wbin + 1'b1;
    end
    if (!wr_rst_b)
    begin
      w_nxt.wbin = '0;
      w_nxt.rq1 = '0;
      w_nxt.rq2 = '0;
    end
  end

  // Read side next state
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.wq1 = wgray;
    r_nxt.wq2 = r_r.wq1;
    if (rd_valid && rd_ready)
      r_nxt.rbin = r_r.rbin + 1'b1;
    if (!rd_rst_b)
    begin
      r_nxt.rbin = '0;
      r_nxt.wq1 = '0;
      r_nxt.wq2 = '0;
    end
  end

  // Write side registers
  always_ff @(posedge wr_clk)
    w_r <= w_nxt;

  // Read side registers
  always_ff @(posedge rd_clk)
    r_r <= r_nxt;

endmodule

`default_nettype wire

// ---- pom_sink.sv ----
/*
  Downstream sink model: samples the output bus on the word clock.
  Assumes the stage under test drives pclk_o and a one cycle word_strobe.
*/
`default_nettype none

module pom_sink (
  // Word clock and stall request
  input wire logic pclk,
  input wire logic stall,
  output logic out_hold,
  // Sampled bus
  input wire logic word_strobe,
  input wire logic [9:0] dout,
  input wire logic [3:0] stat,
  input wire logic [3:0] stat_oe_b,
  output logic [17:0] last,
  output int n_got
);
  timeunit 1ns;
  timeprecision 1ps;

  // Power up state
  initial
  begin
    out_hold = 1'b0;
    last = '0;
    n_got = 0;
  end

  // Bus and status taken together on one word clock edge
  always @(posedge pclk)
  begin
    out_hold <= stall;
    if (word_strobe === 1'b1)
    begin
      last <= {stat_oe_b, stat, dout};
      n_got <= n_got + 1;
    end
  end
endmodule

`default_nettype wire

// ---- parallel_output_status_mux_tb.sv ----
/*
  Self-checking bench of the output stage: modes, selects, buffer, reset.
  Assumes pom_top and pom_sink are compiled alongside.
*/
`default_nettype none
`include "pom_defs.svh"

module parallel_output_status_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, link_clk, rst_b, in_valid, in_ready, stall, out_hold;
  logic [9:0] raw_word, aligned_word, dout_o;
  logic [7:0] asi_byte, src;
  logic code_word_fault, sync_char_flag, video_detected;
  logic transport_detected, buf_extract_mode, auto_mode;
  logic vid_drv, trn_drv, vid_o, vid_oe_b, trn_o, trn_oe_b, vid_pin, trn_pin;
  logic sel_wr_en, pclk_o, pclk_oe_b, dout_oe_b, word_strobe;
  logic [1:0] sel_addr, format_status;
  logic [2:0] sel_wdata, sel_rdata;
  logic [3:0] stat_o, stat_oe_b;
  logic [17:0] last;
  int n_got, num_errors, n_checks, cyc;

  // Format pin wire levels
  assign vid_pin = (vid_oe_b === 1'b0) ? vid_o : vid_drv;
  assign trn_pin = (trn_oe_b === 1'b0) ? trn_o : trn_drv;

  pom_top u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .link_clk(link_clk),
    .in_valid(in_valid), .in_ready(in_ready), .raw_word(raw_word),
    .aligned_word(aligned_word), .asi_byte(asi_byte),
    .code_word_fault(code_word_fault), .sync_char_flag(sync_char_flag),
    .video_detected(video_detected),
    .transport_detected(transport_detected),
    .buf_extract_mode(buf_extract_mode), .hblank(src[0]),
    .vblank(src[1]), .field_id(src[2]), .buffer_load_pulse(src[3]),
    .aux_packet_flag(src[4]), .error_packet_flag(src[5]),
    .buffer_full(src[6]), .buffer_empty(src[7]), .auto_mode(auto_mode),
    .video_decode_select_i(vid_pin), .video_decode_select_o(vid_o),
    .video_decode_select_oe_b(vid_oe_b),
    .transport_mode_select_i(trn_pin), .transport_mode_select_o(trn_o),
    .transport_mode_select_oe_b(trn_oe_b), .sel_wr_en(sel_wr_en),
    .sel_addr(sel_addr), .sel_wdata(sel_wdata), .sel_rdata(sel_rdata),
    .format_status(format_status), .out_hold(out_hold),
    .pclk_o(pclk_o), .pclk_oe_b(pclk_oe_b), .dout_o(dout_o),
    .dout_oe_b(dout_oe_b), .stat_o(stat_o), .stat_oe_b(stat_oe_b),
    .word_strobe(word_strobe)
  );

  pom_sink u_sink (
    .pclk(pclk_o), .stall(stall), .out_hold(out_hold),
    .word_strobe(word_strobe), .dout(dout_o), .stat(stat_o),
    .stat_oe_b(stat_oe_b), .last(last), .n_got(n_got)
  );

  // System clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Word clock, unrelated phase
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_sel(input logic [1:0] a, input logic [2:0] d);
    @(negedge sys_clk);
    sel_wr_en = 1'b1;
    sel_addr = a;
    sel_wdata = d;
    @(negedge sys_clk);
    sel_wr_en = 1'b0;
  endtask

  // Reads all four selects against packed expectations
  task automatic check_sels(input logic [11:0] e);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge sys_clk);
      sel_addr = i[1:0];
      repeat (2) @(negedge sys_clk);
      chk(18'(sel_rdata), 18'(e[3*i +: 3]));
    end
  endtask

  task automatic set_mode(input logic v, input logic t, input logic x);
    @(negedge sys_clk);
    vid_drv = v;
    trn_drv = t;
    buf_extract_mode = x;
    repeat (6) @(negedge sys_clk);
  endtask

  // One word in; optionally waits for it at the sink
  task automatic push(input logic [9:0] w, input logic [7:0] s,
                      input bit wt);
    int n0;
    int k;
    n0 = n_got;
    k = 0;
    @(negedge sys_clk);
    while (in_ready !== 1'b1 && k < 50)
    begin
      @(negedge sys_clk);
      k++;
    end
    raw_word = w;
    aligned_word = ~w;
    asi_byte = ~w[7:0];
    code_word_fault = w[9];
    sync_char_flag = w[8];
    src = s;
    in_valid = 1'b1;
    @(negedge sys_clk);
    in_valid = 1'b0;
    k = 0;
    while (wt && n_got == n0 && k < 100)
    begin
      @(negedge sys_clk);
      k++;
    end
  endtask

  task automatic s_thru();
    check_sels(12'h000);
    chk(18'(format_status), 18'h0);
    wr_sel(2'h2, 3'h5);
    check_sels(12'h140);
    push(10'h2a5, 8'hff, 1'b1);
    chk(18'(last[9:0]), 18'h2a5);
    chk(18'(last[17:14]), 18'hf);
  endtask

  task automatic s_video();
    set_mode(1'b1, 1'b0, 1'b1);
    check_sels(12'h688);
    chk(18'(format_status), 18'h1);
    push(10'h1c3, 8'h05, 1'b1);
    chk(18'(last[9:0]), 18'h23c);
    chk(18'(last[17:10]), 18'h05);
    wr_sel(2'h0, 3'h6);
    wr_sel(2'h1, 3'h4);
    wr_sel(2'h2, 3'h5);
    wr_sel(2'h3, 3'h7);
    push(10'h001, 8'h70, 1'b1);
    chk(18'(last[17:14]), 18'h9);
    chk(18'(last[12:11]), 18'h3);
  endtask

  task automatic s_asi();
    set_mode(1'b0, 1'b1, 1'b0);
    check_sels(12'h03e);
    chk(18'(format_status), 18'h2);
    push(10'h2c1, 8'h40, 1'b1);
    chk(18'(last[9:0]), 18'h23e);
    chk(18'(last[17:10]), 18'hc1);
  endtask

  // Buffer filled under stall, then drained
  task automatic s_fill();
    int n0;
    int k;
    stall = 1'b1;
    repeat (4) @(negedge sys_clk);
    n0 = n_got;
    for (int i = 0; i < 16; i++)
      push(10'(i), 8'h00, 1'b0);
    @(negedge sys_clk);
    chk(18'(in_ready), 18'h0);
    // Word offered while full must be refused
    push(10'h3ff, 8'h00, 1'b0);
    stall = 1'b0;
    k = 0;
    while (n_got < n0 + 16 && k < 200)
    begin
      @(negedge sys_clk);
      k++;
    end
    repeat (10) @(negedge sys_clk);
    chk(18'(n_got - n0), 18'h10);
    chk(18'(last[9:0]), 18'h0f0);
  endtask

  task automatic s_auto();
    auto_mode = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(18'({vid_oe_b, trn_oe_b, vid_o, trn_o}), 18'h0);
    push(10'h3ff, 8'hff, 1'b1);
    chk(18'(last[9:0]), 18'h0);
    transport_detected = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(18'({trn_oe_b, trn_o}), 18'h1);
    push(10'h000, 8'h40, 1'b1);
    chk(18'(format_status), 18'h2);
    chk(18'(last[9:0]), 18'h0ff);
    chk(18'(last[17:10]), 18'hc1);
  endtask

  task automatic s_reset();
    rst_b = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(18'({dout_oe_b, pclk_oe_b}), 18'h3);
    chk(18'({stat_oe_b, stat_o[1:0]}), 18'h31);
    rst_b = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(18'({dout_oe_b, pclk_oe_b}), 18'h0);
  endtask

  // Main sequence
  initial
  begin
    {in_valid, raw_word, aligned_word, asi_byte, code_word_fault,
     sync_char_flag, video_detected, transport_detected, buf_extract_mode,
     src, auto_mode, vid_drv, trn_drv, sel_wr_en, sel_addr, sel_wdata,
     stall} = '0;
    rst_b = 1'b0;
    num_errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk(18'(pclk_oe_b), 18'h0);
    s_thru();
    s_video();
    s_asi();
    s_fill();
    s_auto();
    s_reset();
    complete_run();
  end
endmodule

`default_nettype wire
